//--- hw/smbus_target.sv
// smbus target with strapped address and a nine byte register bank
`timescale 1ns/100ps
module smbus_target (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] strap_level,
	input wire logic [7:0] monitor [7],
	input wire logic [5:0] string12_flags,
	output logic [1:0] string_unused,
	output logic [7:0] current_adjust,
	output logic strap_taken
);

	typedef enum logic [2:0] {
		st_idle, st_addr, st_ack_addr, st_rx, st_ack_rx, st_tx, st_ack_tx
	} bus_state_e;

	// ****************************************************************
	// pin synchronisers and bus events
	// ****************************************************************
	logic scl;
	logic sda;
	logic scl_prev;
	logic sda_prev;
	logic [1:0] strap_sync;

	pin_sync #(.WIDTH(2), .RESET_VALUE(2'h3)) bus_sync (
		.clock(clock),
		.rst(rst),
		.pin({scl_in, sda_in}),
		.synced({scl, sda})
	);

	pin_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) strap_pin_sync (
		.clock(clock),
		.rst(rst),
		.pin(strap_level),
		.synced(strap_sync)
	);

	// events are judged on synchronised copies, never on the first stage
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	assign scl_rise = scl && !scl_prev;
	assign scl_fall = !scl && scl_prev;
	assign start_seen = scl && scl_prev && sda_prev && !sda;
	assign stop_seen = scl && scl_prev && !sda_prev && sda;

	// ****************************************************************
	// address strap capture
	// ****************************************************************
	logic [1:0] settle;
	logic [6:0] own_addr;
	logic [1:0] next_settle;
	logic [6:0] next_own_addr;
	logic next_strap_taken;

	// strap is caught once, a few clocks after reset release
	always_comb begin
		next_settle = settle;
		next_own_addr = own_addr;
		next_strap_taken = strap_taken;
		if (!strap_taken) begin
			next_settle = settle + 2'h1;
			if (settle == smbus_target_pkg::STRAP_SETTLE) begin
				next_strap_taken = 1'b1;
				unique case (strap_sync)
					smbus_target_pkg::STRAP_OPEN: begin
						next_own_addr = smbus_target_pkg::ADDR_OPEN;
					end
					smbus_target_pkg::STRAP_VDD: begin
						next_own_addr = smbus_target_pkg::ADDR_VDD;
					end
					default: begin
						next_own_addr = smbus_target_pkg::ADDR_GND;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			settle <= 2'h0;
			own_addr <= smbus_target_pkg::ADDR_GND;
			strap_taken <= 1'b0;
		end else begin
			settle <= next_settle;
			own_addr <= next_own_addr;
			strap_taken <= next_strap_taken;
		end
	end

	// ****************************************************************
	// register read mux
	// ****************************************************************
	logic [7:0] ptr;
	logic [7:0] read_byte;

	always_comb begin
		read_byte = smbus_target_pkg::ZERO_BYTE;
		if (ptr <= smbus_target_pkg::REG_ANODE) begin
			read_byte = monitor[ptr[2:0]];
		end else if (ptr == smbus_target_pkg::REG_STRING12) begin
			read_byte = {string_unused, string12_flags};
		end else if (ptr == smbus_target_pkg::REG_STRING34) begin
			read_byte = monitor[5];
		end else if (ptr == smbus_target_pkg::REG_FAULT) begin
			read_byte = monitor[6];
		end else if (ptr == smbus_target_pkg::REG_ADJUST) begin
			read_byte = current_adjust;
		end
		// out of range reads as zero (default above)
	end

	// ****************************************************************
	// bus protocol engine
	// ****************************************************************
	bus_state_e state;
	bus_state_e next_state;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] next_ptr;
	logic have_cmd;
	logic next_have_cmd;
	logic next_sda_oe;
	logic [1:0] next_string_unused;
	logic [7:0] next_current_adjust;

	// target only, open drain
	// open-drain pin only ever pulls low, so the host can never be overdriven
	assign sda_out = 1'b0;

	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shift = shift;
		next_ptr = ptr;
		next_have_cmd = have_cmd;
		next_sda_oe = sda_oe;
		next_string_unused = string_unused;
		next_current_adjust = current_adjust;
		if (start_seen && strap_taken) begin
			next_state = st_addr;
			next_bitcnt = 4'h0;
			next_have_cmd = 1'b0;
			next_sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_state = st_idle;
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
				st_idle: begin
					next_sda_oe = 1'b0;
				end
				st_addr: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall
						&& bitcnt == smbus_target_pkg::BYTE_BITS) begin
						if (shift[7:1] == own_addr) begin
							next_state = st_ack_addr;
							next_sda_oe = 1'b1;
						end else begin
							next_state = st_idle;
						end
					end
				end
				st_ack_addr: begin
					if (scl_fall) begin
						next_bitcnt = 4'h0;
						if (shift[0]) begin
							next_state = st_tx;
							next_shift = read_byte;
							next_sda_oe = !read_byte[7];
						end else begin
							next_state = st_rx;
							next_sda_oe = 1'b0;
						end
					end
				end
				st_rx: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall
						&& bitcnt == smbus_target_pkg::BYTE_BITS) begin
						next_state = st_ack_rx;
						next_sda_oe = 1'b1;
						if (!have_cmd) begin
							next_ptr = shift;
							next_have_cmd = 1'b1;
						end else begin
							next_ptr = ptr + 8'h01;
							// writes past the bank are dropped
							if (ptr == smbus_target_pkg::REG_ADJUST) begin
								next_current_adjust = shift;
							end else if (ptr
								== smbus_target_pkg::REG_STRING12) begin
								// only the top two bits are host bits
								next_string_unused =
									shift[7:smbus_target_pkg::STR12_UNUSED_LSB];
							end
						end
					end
				end
				st_ack_rx: begin
					if (scl_fall) begin
						next_state = st_rx;
						next_bitcnt = 4'h0;
						next_sda_oe = 1'b0;
					end
				end
				st_tx: begin
					if (scl_fall) begin
						next_bitcnt = bitcnt + 4'h1;
						if (bitcnt == smbus_target_pkg::LAST_TX_BIT) begin
							// release for the host acknowledge
							next_state = st_ack_tx;
							next_sda_oe = 1'b0;
							next_ptr = ptr + 8'h01;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_sda_oe = !shift[6];
						end
					end
				end
				st_ack_tx: begin
					if (scl_rise && sda) begin
						// host nack ends the read
						next_state = st_idle;
					end else if (scl_fall) begin
						// word reads continue at next register
						next_state = st_tx;
						next_bitcnt = 4'h0;
						next_shift = read_byte;
						next_sda_oe = !read_byte[7];
					end
				end
				// code 7 is unused; fall back to a silent idle bus
				default: begin
					next_state = st_idle;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= st_idle;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			have_cmd <= 1'b0;
			sda_oe <= 1'b0;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			string_unused <= smbus_target_pkg::UNUSED_RESET;
			current_adjust <= smbus_target_pkg::ADJUST_RESET;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shift <= next_shift;
			ptr <= next_ptr;
			have_cmd <= next_have_cmd;
			sda_oe <= next_sda_oe;
			scl_prev <= scl;
			sda_prev <= sda;
			string_unused <= next_string_unused;
			current_adjust <= next_current_adjust;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_strap_address: assert property (
		strap_taken |-> (own_addr == smbus_target_pkg::ADDR_GND
			|| own_addr == smbus_target_pkg::ADDR_OPEN
			|| own_addr == smbus_target_pkg::ADDR_VDD))
		else $error("own address is not a strap code");

	a_match_acks: assert property (
		(state == st_addr && scl_fall && !start_seen && !stop_seen
			&& bitcnt == smbus_target_pkg::BYTE_BITS
			&& shift[7:1] == own_addr) |=> sda_oe ##0 state == st_ack_addr)
		else $error("matching address not acknowledged");

	a_foreign_silent: assert property (
		(state == st_addr && scl_fall && !start_seen && !stop_seen
			&& bitcnt == smbus_target_pkg::BYTE_BITS
			&& shift[7:1] != own_addr) |=> !sda_oe && state == st_idle)
		else $error("foreign address not ignored");

	a_idle_quiet: assert property (
		(state == st_idle && $past(state) == st_idle) |-> !sda_oe)
		else $error("pin pulled low while idle");

	a_adjust_cause: assert property (
		$changed(current_adjust) |-> $past(state == st_rx && have_cmd
			&& ptr == smbus_target_pkg::REG_ADJUST))
		else $error("adjust register changed without host write");

	a_high_reads_zero: assert property (
		(ptr > smbus_target_pkg::LAST_REG) |-> read_byte == 8'h00)
		else $error("read beyond bank not zero");

	a_tx_bit_drive: assert property (
		(state == st_tx && scl_rise) |-> sda_oe == !shift[7])
		else $error("transmitted bit does not match shift register");

	a_ptr_advance: assert property (
		(state == st_rx && scl_fall && have_cmd && !start_seen
			&& !stop_seen && bitcnt == smbus_target_pkg::BYTE_BITS)
			|=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after data byte");

	a_ack_release: assert property (
		(state == st_ack_rx && scl_fall && !start_seen && !stop_seen)
			|=> !sda_oe [*2])
		else $error("acknowledge not released after clock fall");

endmodule

//--- shared/smbus_target_pkg.sv
// constants shared by the strapped smbus target and its helpers
package smbus_target_pkg;

	// register bank layout
	localparam int NUM_REGS = 9;
	localparam logic [7:0] REG_DRAIN1 = 8'h00;
	localparam logic [7:0] REG_DRAIN4 = 8'h03;
	localparam logic [7:0] REG_ANODE = 8'h04;
	localparam logic [7:0] REG_STRING12 = 8'h05;
	localparam logic [7:0] REG_STRING34 = 8'h06;
	localparam logic [7:0] REG_FAULT = 8'h07;
	localparam logic [7:0] REG_ADJUST = 8'h08;
	localparam logic [7:0] LAST_REG = 8'h08;

	// field positions of the string 1 and 2 register
	localparam int STR12_UNUSED_LSB = 6;
	localparam int STR12_FLAGS_W = 6;

	// reset values
	localparam logic [7:0] ADJUST_RESET = 8'h00;
	localparam logic [1:0] UNUSED_RESET = 2'h0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// strap pin levels and the target address each selects
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_VDD = 2'h2;
	localparam logic [6:0] ADDR_GND = 7'h2C;
	localparam logic [6:0] ADDR_OPEN = 7'h2E;
	localparam logic [6:0] ADDR_VDD = 7'h2F;

	// cycles after reset release before the strap is captured
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// bits in a byte, counted on the bus
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

endpackage

//--- hw/pin_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_synced;

	// first stage feeds only the second stage
	always_comb begin
		next_stage1 = pin;
		next_synced = stage1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			synced <= RESET_VALUE;
		end else begin
			stage1 <= next_stage1;
			synced <= next_synced;
		end
	end

endmodule

//--- verification/smbus_host.sv
// host master model that drives the two-wire bus of the target
`timescale 1ns/100ps
module smbus_host (
	input wire logic clock,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// ********************
	// idle bus
	// ********************
	// clock driven high by the host; data line released, its pull-up holds it high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clock);
	endtask

	// standard bit timing
	// data moves only while the clock is low; low phase is over 4.7 us
	task automatic clk_bit(input logic b, output logic r);
		wait_clk(10);
		sda_low = !b;
		wait_clk(110);
		scl = 1'b1;
		wait_clk(50);
		r = sda_line;
		wait_clk(50);
		scl = 1'b0;
	endtask

	task automatic bus_start();
		wait_clk(10);
		sda_low = 1'b0;
		wait_clk(110);
		scl = 1'b1;
		wait_clk(120);
		sda_low = 1'b1;
		wait_clk(100);
		scl = 1'b0;
	endtask

	task automatic bus_stop();
		wait_clk(10);
		sda_low = 1'b1;
		wait_clk(110);
		scl = 1'b1;
		wait_clk(120);
		sda_low = 1'b0;
		wait_clk(120);
	endtask

	// byte out, msb first, then the target's ack bit
	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v[i], r);
		end
		clk_bit(1'b1, r);
		ack = !r;
	endtask

	// byte in; ack asks for more, nack ends the read
	task automatic get_byte(input logic ack_it, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			v[i] = r;
		end
		clk_bit(!ack_it, r);
	endtask
endmodule

//--- verification/smbus_target_test.sv
// self-checking bench for the strapped smbus target
`timescale 1ns/100ps
`define check(got, exp) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("wrong value at %0t: got %0h want %0h", $time, got, exp); \
	end \
end
module smbus_target_test;
	logic clock;
	logic rst;
	logic [1:0] strap_level;
	logic [7:0] monitor [7];
	logic [5:0] string12_flags;
	logic sda_oe;
	logic sda_out;
	logic scl;
	logic host_low;
	logic strap_taken;
	logic [1:0] string_unused;
	logic [7:0] current_adjust;
	logic sda_line;
	int fail_count;
	int total_checks;
	logic [6:0] addr;
	logic ack;
	logic [7:0] data;

	// ********************
	// bus wiring
	// ********************
	// open drain data line with pull-up: low if either side pulls
	assign sda_line = !(host_low || sda_oe);

	smbus_target i_smbus_target (
		.clock(clock),
		.rst(rst),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.strap_level(strap_level),
		.monitor(monitor),
		.string12_flags(string12_flags),
		.string_unused(string_unused),
		.current_adjust(current_adjust),
		.strap_taken(strap_taken)
	);

	smbus_host i_smbus_host (
		.clock(clock),
		.sda_line(sda_line),
		.scl(scl),
		.sda_low(host_low)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ********************
	// helpers
	// ********************
	// strap must be steady before capture, so it changes inside reset
	task automatic do_reset(input logic [1:0] level);
		@(negedge clock);
		rst = 1'b1;
		strap_level = level;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (10) @(negedge clock);
	endtask

	task automatic send(input logic [7:0] v, input logic exp_ack);
		i_smbus_host.put_byte(v, ack);
		`check(ack, exp_ack)
	endtask

	task automatic write_cmd(input logic [7:0] cmd);
		i_smbus_host.bus_start();
		send({addr, 1'b0}, 1'b1);
		send(cmd, 1'b1);
	endtask

	task automatic read_at(input logic [7:0] cmd, input logic more);
		write_cmd(cmd);
		i_smbus_host.bus_start();
		send({addr, 1'b1}, 1'b1);
		i_smbus_host.get_byte(more, data);
	endtask

	// ********************
	// scenarios
	// ********************
	// wrong address is ignored until the repeated start that follows
	task automatic test_strap();
		logic [6:0] want [4];
		want = '{7'h2C, 7'h2E, 7'h2F, 7'h2C};
		// strap code 3 is taken as ground
		for (int s = 0; s < 4; s++) begin
			do_reset(2'(s));
			`check(strap_taken, 1'b1)
			`check(current_adjust, 8'h00)
			`check(sda_out, 1'b0)
			addr = want[s];
			i_smbus_host.bus_start();
			send({addr ^ 7'h02, 1'b0}, 1'b0);
			// own address after a foreign one is still ignored
			send({addr, 1'b0}, 1'b0);
			i_smbus_host.bus_start();
			send({addr, 1'b0}, 1'b1);
			i_smbus_host.bus_stop();
		end
		$display("test strap done");
	endtask

	// word write starting on a read-only register, then read past end
	task automatic test_word();
		write_cmd(8'h07);
		send(8'h3C, 1'b1);
		send(8'hC3, 1'b1);
		i_smbus_host.bus_stop();
		`check(current_adjust, 8'hC3)
		read_at(8'h07, 1'b1);
		`check(data, 8'h77)
		i_smbus_host.get_byte(1'b0, data);
		`check(data, 8'hC3)
		i_smbus_host.bus_stop();
		i_smbus_host.bus_start();
		send({addr, 1'b1}, 1'b1);
		i_smbus_host.get_byte(1'b0, data);
		`check(data, 8'h00)
		i_smbus_host.bus_stop();
		$display("test word done");
	endtask

	// only the top two bits of the string register take writes
	task automatic test_string();
		write_cmd(8'h05);
		send(8'hFF, 1'b1);
		i_smbus_host.bus_stop();
		`check(string_unused, 2'h3)
		read_at(8'h05, 1'b0);
		`check(data, {2'h3, 6'h2A})
		i_smbus_host.bus_stop();
		$display("test string done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		fail_count = 0;
		total_checks = 0;
		rst = 1'b1;
		strap_level = 2'h0;
		string12_flags = 6'h2A;
		addr = 7'h00;
		for (int i = 0; i < 7; i++) begin
			monitor[i] = 8'(8'h11 * (i + 1));
		end
		test_strap();
		test_word();
		test_string();
		report_and_stop();
	end

	// a hung bus cycle would otherwise stall the run
	initial begin
		repeat (80000) @(posedge clock);
		fail_count++;
		report_and_stop();
	end
endmodule
